/* File: rtl/flash_seq_pkg.sv */
// Shared constants and carriers for the serial flash page sequencer.
// Assumes a 100 MHz core clock; the serial link is sampled, not a clock domain.
package flash_seq_pkg;
    localparam logic [7:0] OP_PROG_THRU_BUF = 8'h82;
    localparam logic [7:0] OP_PAGE_TO_BUF = 8'h53;
    localparam logic [7:0] OP_PAGE_COMPARE = 8'h60;
    localparam logic [7:0] OP_AUTO_REWRITE = 8'h58;
    localparam logic [7:0] OP_STATUS_A = 8'h57;
    localparam logic [7:0] OP_STATUS_B = 8'hd7;
    localparam int CMD_BITS = 32;          // opcode plus 24 address bits
    localparam int BUF_BYTES = 264;
    localparam int PAGES = 512;
    localparam logic [8:0] LAST_BUF_BYTE = 9'h107;
    localparam logic [8:0] PROTECT_PAGES = 9'h100;  // first 256 pages
    localparam logic [3:0] DENSITY_CODE = 4'h3;
    localparam int CLK_PERIOD_NS = 10;
    localparam int ERASE_PROGRAM_TIME_NS = 20000000;  // longest self-timed erase+program
    localparam int PAGE_TRANSFER_TIME_NS = 120000;
    localparam int ERASE_PROGRAM_CYCLES = ERASE_PROGRAM_TIME_NS / CLK_PERIOD_NS;
    localparam int PAGE_TRANSFER_CYCLES = PAGE_TRANSFER_TIME_NS / CLK_PERIOD_NS;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_WIDTH = 8;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_XFER = 6'h02,
        ST_COMPARE = 6'h04,
        ST_ERASE = 6'h08,
        ST_PROGRAM = 6'h10,
        ST_WAIT = 6'h20
    } op_state_e;

    typedef enum logic [2:0] {
        K_NONE = 3'h0,
        K_PROG = 3'h1,
        K_XFER = 3'h2,
        K_CMP = 3'h3,
        K_REWRITE = 3'h4,
        K_STATUS = 3'h5
    } cmd_kind_e;

    // Serial front-end: synchronisers, shifter and frame bookkeeping
    typedef struct packed {
        logic [1:0] cs_sync;
        logic [1:0] sck_sync;
        logic [1:0] si_sync;
        logic cs_q;
        logic sck_q;
        logic mode3;
        logic [5:0] bit_cnt;
        logic [31:0] shift;
        logic [7:0] data_sh;
        logic [2:0] data_cnt;
        cmd_kind_e kind;
        logic [7:0] stat_sh;
        logic [2:0] stat_cnt;
        logic so_out;
        logic so_en;
        logic [8:0] page;
        logic [8:0] wr_ptr;
    } link_s;

    // Array engine: operation state, timer, scan pointer
    typedef struct packed {
        op_state_e state;
        cmd_kind_e kind;
        logic [8:0] page;
        logic [8:0] idx;
        logic [31:0] timer;
        logic mismatch;
        logic comp;
        logic protect_hit;
    } engine_s;
endpackage

/* File: rtl/flash_seq.sv */
// Serial flash page sequencer: SPI command front end, byte FIFO, buffer and array engine.
// Assumes the host drives CS/SCK/SI asynchronously; all sampled on CORE_CLK.
`timescale 1ns/100ps

module flash_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] rd_ff;
    logic [AW:0] wr_ff;
    logic push;
    logic pop;

    // Extra pointer bit separates full from empty
    assign in_ready = (wr_ff - rd_ff) != DEPTH[AW:0];
    assign out_valid = wr_ff != rd_ff;
    assign out_data = mem[rd_ff[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointers and storage
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rd_ff <= '0;
            wr_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= rd_ff + 1'b1;
            end
        end
        if (push) begin
            mem[wr_ff[AW-1:0]] <= in_data;
        end
    end
endmodule // flash_fifo

module flash_seq
    import flash_seq_pkg::*;
#(
    parameter int EP_CYCLES = ERASE_PROGRAM_CYCLES,
    parameter int XFR_CYCLES = PAGE_TRANSFER_CYCLES
) (
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic CS_N,
    input wire logic SCK,
    input wire logic SI,
    input wire logic WP_N,
    output logic SO,
    output logic SO_OE,
    output logic BUSY,
    output logic COMPARE_MISMATCH,
    output logic PROTECT_REFUSED
);
    link_s lk_ff;
    link_s nxt_lk;
    engine_s en_ff;
    engine_s nxt_en;
    logic [7:0] buffer_mem [BUF_BYTES];
    logic [7:0] array_mem [PAGES][BUF_BYTES];
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    logic cs_low;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [7:0] fifo_out_data;
    logic [7:0] status_byte;
    logic [8:0] fifo_ptr_ff;
    logic buf_wr;
    logic arr_wr;
    logic [7:0] arr_rd;
    logic [1:0] wp_sync_ff;  // Write protect is a pin: two flops before use

    // Edge detection reads only the second synchroniser stage
    assign cs_low = !lk_ff.cs_sync[1];
    assign cs_fall = lk_ff.cs_q && !lk_ff.cs_sync[1];
    assign cs_rise = !lk_ff.cs_q && lk_ff.cs_sync[1];
    assign sck_rise = cs_low && !lk_ff.sck_q && lk_ff.sck_sync[1];
    assign sck_fall = cs_low && lk_ff.sck_q && !lk_ff.sck_sync[1];
    assign status_byte = {!BUSY, en_ff.comp, DENSITY_CODE, 2'b00};
    assign arr_rd = array_mem[en_ff.page][en_ff.idx];

    // Serial front end
    always_comb begin
        nxt_lk = lk_ff;
        fifo_in_valid = 1'b0;
        nxt_lk.cs_sync = {lk_ff.cs_sync[0], CS_N};
        nxt_lk.sck_sync = {lk_ff.sck_sync[0], SCK};
        nxt_lk.si_sync = {lk_ff.si_sync[0], SI};
        nxt_lk.cs_q = lk_ff.cs_sync[1];
        nxt_lk.sck_q = lk_ff.sck_sync[1];
        if (cs_fall) begin
            nxt_lk.mode3 = lk_ff.sck_sync[1];
            nxt_lk.bit_cnt = '0;
            nxt_lk.kind = K_NONE;
            nxt_lk.data_cnt = '0;
        end
        if (sck_rise) begin
            if (lk_ff.bit_cnt < 6'(CMD_BITS)) begin
                nxt_lk.shift = {lk_ff.shift[30:0], lk_ff.si_sync[1]};
                nxt_lk.bit_cnt = lk_ff.bit_cnt + 6'h01;
                // Status read answers after eight opcode bits
                if (lk_ff.bit_cnt == 6'h07 &&
                    ({lk_ff.shift[6:0], lk_ff.si_sync[1]} == OP_STATUS_A ||
                     {lk_ff.shift[6:0], lk_ff.si_sync[1]} == OP_STATUS_B)) begin
                    nxt_lk.kind = K_STATUS;
                    nxt_lk.bit_cnt = 6'(CMD_BITS) + 6'h01;
                    nxt_lk.stat_cnt = '0;
                end
                if (lk_ff.bit_cnt == 6'(CMD_BITS - 1)) begin
                    // Page bits sit after opcode and six reserved bits
                    nxt_lk.page = lk_ff.shift[16:8];
                    nxt_lk.wr_ptr = {lk_ff.shift[7:0], lk_ff.si_sync[1]};
                    unique case (lk_ff.shift[30:23])
                        OP_PROG_THRU_BUF: nxt_lk.kind = K_PROG;
                        OP_PAGE_TO_BUF: nxt_lk.kind = K_XFER;
                        OP_PAGE_COMPARE: nxt_lk.kind = K_CMP;
                        OP_AUTO_REWRITE: nxt_lk.kind = K_REWRITE;
                        default: nxt_lk.kind = K_NONE;
                    endcase
                end
            end else if (lk_ff.kind == K_PROG && en_ff.state == ST_IDLE) begin
                nxt_lk.data_sh = {lk_ff.data_sh[6:0], lk_ff.si_sync[1]};
                nxt_lk.data_cnt = lk_ff.data_cnt + 3'h1;
                if (lk_ff.data_cnt == 3'h7) begin
                    fifo_in_valid = 1'b1;
                end
            end
        end
        // Status shifts out MSB first, repeating, on falling SCK
        if (lk_ff.kind == K_STATUS && (sck_fall || (sck_rise && lk_ff.bit_cnt == 6'h07))) begin
            if (lk_ff.stat_cnt == 3'h0) begin
                nxt_lk.stat_sh = {status_byte[6:0], 1'b0};
                nxt_lk.so_out = status_byte[7];
            end else begin
                nxt_lk.stat_sh = {lk_ff.stat_sh[6:0], 1'b0};
                nxt_lk.so_out = lk_ff.stat_sh[7];
            end
            nxt_lk.stat_cnt = lk_ff.stat_cnt + 3'h1;
        end
        nxt_lk.so_en = cs_low && lk_ff.kind == K_STATUS;
        if (!cs_low) begin
            nxt_lk.kind = cs_fall ? K_NONE : lk_ff.kind;
        end
    end

    // Array engine sequencing
    always_comb begin
        nxt_en = en_ff;
        buf_wr = 1'b0;
        arr_wr = 1'b0;
        unique case (en_ff.state)
            ST_IDLE: begin
                // Only a complete decoded command launches anything
                if (cs_rise && lk_ff.kind != K_NONE && lk_ff.kind != K_STATUS) begin
                    nxt_en.kind = lk_ff.kind;
                    nxt_en.page = lk_ff.page;
                    nxt_en.idx = '0;
                    nxt_en.timer = '0;
                    nxt_en.mismatch = 1'b0;
                    nxt_en.protect_hit = !wp_sync_ff[1] && lk_ff.page < PROTECT_PAGES;
                    unique case (lk_ff.kind)
                        K_PROG: nxt_en.state = ST_WAIT;  // Drain FIFO first
                        K_CMP: nxt_en.state = ST_COMPARE;
                        default: nxt_en.state = ST_XFER;
                    endcase
                end
            end
            ST_WAIT: begin
                if (!fifo_out_valid) begin
                    nxt_en.state = ST_ERASE;
                end
            end
            ST_XFER: begin
                buf_wr = en_ff.idx <= LAST_BUF_BYTE;
                nxt_en.idx = (en_ff.idx <= LAST_BUF_BYTE) ? en_ff.idx + 9'h001 : en_ff.idx;
                nxt_en.timer = en_ff.timer + 32'h1;
                if (en_ff.timer >= 32'(XFR_CYCLES - 1)) begin
                    nxt_en.timer = '0;
                    nxt_en.idx = '0;
                    nxt_en.state = (en_ff.kind == K_REWRITE) ? ST_ERASE : ST_IDLE;
                end
            end
            ST_COMPARE: begin
                if (en_ff.idx <= LAST_BUF_BYTE) begin
                    nxt_en.idx = en_ff.idx + 9'h001;
                    if (arr_rd != buffer_mem[en_ff.idx]) begin
                        nxt_en.mismatch = 1'b1;
                    end
                end
                nxt_en.timer = en_ff.timer + 32'h1;
                if (en_ff.timer >= 32'(XFR_CYCLES - 1)) begin
                    nxt_en.comp = en_ff.mismatch;
                    nxt_en.state = ST_IDLE;
                end
            end
            ST_ERASE: begin
                // Half of the erase/program time is spent erasing
                nxt_en.timer = en_ff.timer + 32'h1;
                if (en_ff.timer >= 32'(EP_CYCLES / 2 - 1)) begin
                    nxt_en.timer = '0;
                    nxt_en.idx = '0;
                    nxt_en.state = ST_PROGRAM;
                end
            end
            ST_PROGRAM: begin
                arr_wr = !en_ff.protect_hit && en_ff.idx <= LAST_BUF_BYTE;
                nxt_en.idx = (en_ff.idx <= LAST_BUF_BYTE) ? en_ff.idx + 9'h001 : en_ff.idx;
                nxt_en.timer = en_ff.timer + 32'h1;
                if (en_ff.timer >= 32'(EP_CYCLES - EP_CYCLES / 2 - 1)) begin
                    nxt_en.state = ST_IDLE;
                end
            end
            default: nxt_en.state = ST_IDLE;
        endcase
    end

    // Data bytes are drained into the buffer only between array operations
    assign fifo_out_ready = en_ff.state == ST_IDLE || en_ff.state == ST_WAIT;

    flash_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(CORE_CLK),
        .nrst(NRST),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(nxt_lk.data_sh),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // State registers; buffer write pointer follows the decoded start address
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            lk_ff <= '{cs_sync: 2'b11, sck_sync: 2'b11, si_sync: 2'b00, cs_q: 1'b1, sck_q: 1'b1,
                       mode3: 1'b1, kind: K_NONE, default: '0};
            en_ff <= '{state: ST_IDLE, kind: K_NONE, default: '0};
            fifo_ptr_ff <= '0;
            PROTECT_REFUSED <= 1'b0;
            wp_sync_ff <= 2'b11;
        end else begin
            wp_sync_ff <= {wp_sync_ff[0], WP_N};
            lk_ff <= nxt_lk;
            en_ff <= nxt_en;
            if (sck_rise && lk_ff.bit_cnt == 6'(CMD_BITS - 1)) begin
                fifo_ptr_ff <= {lk_ff.shift[7:0], lk_ff.si_sync[1]};
            end else if (fifo_out_valid && fifo_out_ready) begin
                fifo_ptr_ff <= (fifo_ptr_ff == LAST_BUF_BYTE) ? 9'h000 : fifo_ptr_ff + 9'h001;
            end
            if (en_ff.state == ST_IDLE && nxt_en.state != ST_IDLE) begin
                PROTECT_REFUSED <= nxt_en.protect_hit && nxt_en.kind != K_XFER && nxt_en.kind != K_CMP;
            end
        end
        if (fifo_out_valid && fifo_out_ready) begin
            buffer_mem[fifo_ptr_ff] <= fifo_out_data;
        end else if (buf_wr) begin
            buffer_mem[en_ff.idx] <= arr_rd;
        end
        if (arr_wr) begin
            array_mem[en_ff.page][en_ff.idx] <= buffer_mem[en_ff.idx];
        end
    end

    assign SO = lk_ff.so_out;
    assign SO_OE = lk_ff.so_en;
    assign BUSY = en_ff.state != ST_IDLE;
    assign COMPARE_MISMATCH = en_ff.comp;
endmodule // flash_seq

/* File: dv/flash_seq_checker.sv */
// Port-level timing checks for the flash page sequencer.
// Assumes it is bound to flash_seq and shares its cycle parameters.
`timescale 1ns/100ps
module flash_seq_checker #(
    parameter int EP_CYCLES = 600,
    parameter int XFR_CYCLES = 300
) (
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic CS_N,
    input wire logic BUSY,
    input wire logic SO_OE,
    input wire logic COMPARE_MISMATCH,
    input wire logic PROTECT_REFUSED
);
    // Margin covers the FIFO drain ahead of programming
    localparam int MAX_BUSY = EP_CYCLES + XFR_CYCLES + 200;
    logic [31:0] busy_len_ff;

    // Length of the current busy stretch, cleared while idle
    always_ff @(posedge CORE_CLK) begin
        if (!NRST || !BUSY) begin
            busy_len_ff <= 32'h0;
        end else begin
            busy_len_ff <= busy_len_ff + 32'h1;
        end
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);

    // Chip select seen high long enough to pass the synchronisers
    sequence s_cs_idle;
        CS_N [*5];
    endsequence
    sequence s_cs_closed;
        CS_N && $past(CS_N, 2);
    endsequence

    property p_idle_tristate;
        s_cs_idle |-> !SO_OE;
    endproperty
    a_idle_tristate: assert property (p_idle_tristate) else $error("SO driven while deselected");
    property p_oe_selected;
        SO_OE |-> !(CS_N && $past(CS_N) && $past(CS_N, 2) && $past(CS_N, 3) && $past(CS_N, 4));
    endproperty
    a_oe_selected: assert property (p_oe_selected) else $error("SO enable without chip select");
    property p_busy_launch;
        $rose(BUSY) |-> s_cs_closed;
    endproperty
    a_busy_launch: assert property (p_busy_launch) else $error("busy began inside a frame");
    property p_busy_hold;
        $rose(BUSY) |=> BUSY [*8];
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy pulse too short");
    property p_busy_min;
        $fell(BUSY) |-> busy_len_ff >= XFR_CYCLES;
    endproperty
    a_busy_min: assert property (p_busy_min) else $error("operation ended early");
    property p_busy_max;
        BUSY |-> busy_len_ff < MAX_BUSY;
    endproperty
    a_busy_max: assert property (p_busy_max) else $error("operation ran too long");
    property p_cmp_update;
        $changed(COMPARE_MISMATCH) |-> !BUSY && ($past(BUSY) || $past(BUSY, 2));
    endproperty
    a_cmp_update: assert property (p_cmp_update) else $error("compare flag moved outside completion");
    property p_prot_launch;
        $changed(PROTECT_REFUSED) |-> BUSY && !$past(BUSY, 3);
    endproperty
    a_prot_launch: assert property (p_prot_launch) else $error("protect flag moved outside launch");
    c_done: cover property ($fell(BUSY));
endmodule // flash_seq_checker

bind flash_seq flash_seq_checker #(.EP_CYCLES(EP_CYCLES), .XFR_CYCLES(XFR_CYCLES)) chk (
    .CORE_CLK(CORE_CLK), .NRST(NRST), .CS_N(CS_N), .BUSY(BUSY), .SO_OE(SO_OE),
    .COMPARE_MISMATCH(COMPARE_MISMATCH), .PROTECT_REFUSED(PROTECT_REFUSED));

/* File: dv/host_spi.sv */
// Host SPI master model: frames commands in mode 3 on chip select, SCK and SI.
// Assumes the core clock paces it; one SCK period is 8 core cycles (80 ns).
`timescale 1ns/100ps
module host_spi (
    input wire logic clk,
    input wire logic so,
    output logic cs_n,
    output logic sck,
    output logic si
);
    // SCK stands high between frames, so each CS fall picks mode 3
    initial begin
        cs_n = 1'b1;
        sck = 1'b1;
        si = 1'b0;
    end

    // One SCK period: SI moves while SCK is low, SO sampled late in the high phase
    task automatic clk_bit(input logic b, output logic r);
        sck <= 1'b0;
        si <= b;
        repeat (4) @(posedge clk);
        sck <= 1'b1;
        repeat (3) @(posedge clk);
        r = so;
        @(posedge clk);
    endtask

    // Whole frame: header bits MSB first, data bytes base+k, optional status byte
    task automatic frame(input logic [31:0] hdr, input int nh, input int nd, input logic [7:0] base,
                         input logic rd, output logic [7:0] st);
        logic r;
        logic [7:0] d;
        cs_n <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 0; i < nh; i++) clk_bit(hdr[31-i], r);
        for (int k = 0; k < nd; k++) begin
            d = base + 8'(k);
            for (int j = 7; j >= 0; j--) clk_bit(d[j], r);
        end
        for (int j = 7; j >= 0; j--) begin
            if (rd) clk_bit(1'b0, st[j]);
        end
        cs_n <= 1'b1;
        si <= ~si; // Released line shows no stale level
        repeat (4) @(posedge clk);
    endtask
endmodule // host_spi

/* File: dv/tb_flash_seq.sv */
// Testbench for the flash page sequencer: command frames through the host model.
// Assumes short self-timed counts set by parameter; expectations derive from them.
`timescale 1ns/100ps
module tb_flash_seq;
    import flash_seq_pkg::*;
    localparam int EP = 600;
    localparam int XFR = 300;
    logic CORE_CLK = 1'b0;
    logic NRST = 1'b0;
    logic WP_N = 1'b1;
    logic CS_N, SCK, SI, SO, SO_OE, BUSY, COMPARE_MISMATCH, PROTECT_REFUSED;
    logic [7:0] st;
    int n_errors = 0;
    int checks = 0;

    always #5 CORE_CLK = ~CORE_CLK;

    flash_seq #(.EP_CYCLES(EP), .XFR_CYCLES(XFR)) DUT (
        .CORE_CLK(CORE_CLK), .NRST(NRST), .CS_N(CS_N), .SCK(SCK), .SI(SI), .WP_N(WP_N),
        .SO(SO), .SO_OE(SO_OE), .BUSY(BUSY), .COMPARE_MISMATCH(COMPARE_MISMATCH),
        .PROTECT_REFUSED(PROTECT_REFUSED));
    host_spi host (.clk(CORE_CLK), .so(SO), .cs_n(CS_N), .sck(SCK), .si(SI));

    task automatic check1(input logic got, input logic exp, input string what);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s", $time, what);
        end
    endtask
    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s got %h", $time, what, got);
        end
    endtask
    task automatic report_and_stop;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Bounded wait for the array engine to go idle
    task automatic idle_wait;
        int n;
        n = 0;
        while (BUSY !== 1'b0 && n < EP + XFR + 3000) begin
            @(posedge CORE_CLK);
            n++;
        end
        if (BUSY !== 1'b0) begin
            check1(1'b0, 1'b1, "busy never ended");
            report_and_stop();
        end
    endtask
    task automatic status(output logic [7:0] s);
        host.frame({OP_STATUS_A, 24'h0}, 8, 0, 8'h00, 1'b1, s);
    endtask
    // Launch a full array command, confirm busy, then wait it out
    task automatic run(input logic [7:0] op, input logic [8:0] pg, input logic [8:0] ba, input int nd,
                       input logic [7:0] base);
        logic [7:0] s;
        host.frame({op, 6'h00, pg, ba}, 32, nd, base, 1'b0, s);
        repeat (2) @(posedge CORE_CLK);
        check1(BUSY, 1'b1, "command did not launch");
        idle_wait();
    endtask

    initial begin
        repeat (12) @(posedge CORE_CLK);
        check1(BUSY, 1'b0, "busy in reset");
        check1(SO_OE, 1'b0, "SO enabled in reset");
        check1(COMPARE_MISMATCH | PROTECT_REFUSED, 1'b0, "flags in reset");
        NRST <= 1'b1;
        repeat (3) @(posedge CORE_CLK);
        status(st);
        check8(st, {1'b1, 1'b0, DENSITY_CODE, 2'b00}, "idle status");
        check1(SO_OE, 1'b0, "SO enabled after frame");
        // Full buffer load from byte 5 wraps; byte at address a holds the low 8 bits of (a-5) mod 264
        host.frame({OP_PROG_THRU_BUF, 6'h00, 9'h100, 9'h005}, 32, 264, 8'h00, 1'b0, st);
        repeat (2) @(posedge CORE_CLK);
        status(st);
        check1(st[7], 1'b0, "status during program");
        idle_wait();
        check1(PROTECT_REFUSED, 1'b0, "unprotected page refused");
        run(OP_PAGE_COMPARE, 9'h100, 9'h0, 0, 8'h00);
        check1(COMPARE_MISMATCH, 1'b0, "page equals buffer");
        run(OP_PROG_THRU_BUF, 9'h101, 9'h0, 1, 8'hfc);
        run(OP_PAGE_COMPARE, 9'h100, 9'h0, 0, 8'h00);
        check1(COMPARE_MISMATCH, 1'b1, "byte 0 differs");
        run(OP_PAGE_TO_BUF, 9'h100, 9'h0, 0, 8'h00);
        run(OP_PAGE_COMPARE, 9'h100, 9'h0, 0, 8'h00);
        check1(COMPARE_MISMATCH, 1'b0, "transfer copied page");
        run(OP_AUTO_REWRITE, 9'h101, 9'h0, 0, 8'h00);
        run(OP_PAGE_COMPARE, 9'h100, 9'h0, 0, 8'h00);
        check1(COMPARE_MISMATCH, 1'b1, "rewrite reloaded buffer");
        run(OP_PAGE_COMPARE, 9'h101, 9'h0, 0, 8'h00);
        check1(COMPARE_MISMATCH, 1'b0, "rewrite kept page");
        // Protected page: refused program leaves the old contents
        run(OP_PROG_THRU_BUF, 9'h010, 9'h0, 1, 8'h40);
        check1(PROTECT_REFUSED, 1'b0, "write allowed with WP high");
        WP_N <= 1'b0;
        run(OP_PROG_THRU_BUF, 9'h010, 9'h0, 1, 8'h41);
        check1(PROTECT_REFUSED, 1'b1, "protected page not refused");
        WP_N <= 1'b1;
        run(OP_PAGE_COMPARE, 9'h010, 9'h0, 0, 8'h00);
        check1(COMPARE_MISMATCH, 1'b1, "protected page changed");
        // Frame cut after 12 bits starts nothing
        host.frame({OP_PROG_THRU_BUF, 24'h0}, 12, 0, 8'h00, 1'b0, st);
        repeat (20) @(posedge CORE_CLK);
        check1(BUSY, 1'b0, "short frame launched");
        report_and_stop();
    end
endmodule // tb_flash_seq
